//--- rtl/uirx_baud.sv
/*
 Baud tick generator: one tick every reload system clocks, sixteen
 ticks to a serial bit.
 Assumes reload comes from the register file on the same clock.
*/
`timescale 1ns/1ps
`include "uirx_params.svh"

module uirx_baud (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Reload value and tick out
    input  wire logic [15:0] reload,
    output logic             tick
);
    uirx_pkg::uirx_baud_t s_q;
    uirx_pkg::uirx_baud_t s_d;

    // Count down and reload; a reload of 0 or 1 ticks every clock
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt <= 16'h0001) begin
            s_d.cnt = reload;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : uirx_baud

//--- rtl/uirx_irdec.sv
/*
 Infrared receive decoder: turns optical pulses into a serial line
 with bit cells of sixteen baud ticks.
 Assumes optical_rx_in is already synchronised to clk, pulse high.
*/
`timescale 1ns/1ps
`include "uirx_params.svh"

module uirx_irdec (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Control and timing
    input  wire logic enable,
    input  wire logic tick,
    // Optical in, decoded line out
    input  wire logic optical_rx_in,
    output logic      rx_line
);
    uirx_pkg::uirx_irdec_t s_q;
    uirx_pkg::uirx_irdec_t s_d;
    logic                  pulse;

    always_comb begin
        s_d = s_q;
        s_d.prev = optical_rx_in;
        pulse = optical_rx_in & ~s_q.prev;
        if (!enable) begin
            s_d.active = 1'b0;
            s_d.out = 1'b1;
        end else if (!s_q.active) begin
            if (pulse) begin
                s_d.active = 1'b1;
                s_d.cnt = 4'h0;
                s_d.seen = 1'b1;
                s_d.idle_bits = 4'h0;
                s_d.out = 1'b0;
            end
        end else begin
            if (tick) begin
                s_d.cnt = s_q.cnt + 4'h1;
                if (s_q.cnt == `UIRX_LAST_TICK) begin
                    s_d.out = 1'b1;
                    s_d.seen = 1'b0;
                    if (s_q.seen) begin
                        s_d.idle_bits = 4'h0;
                    end else begin
                        s_d.idle_bits = s_q.idle_bits + 4'h1;
                    end
                    if (!s_q.seen &&
                        s_q.idle_bits == `UIRX_IR_IDLE_BITS) begin
                        s_d.active = 1'b0;
                    end
                end
            end
            if (pulse) begin
                s_d.seen = 1'b1;
                s_d.out = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.out <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rx_line = s_q.out;

    chk_ir_cell_end: assert property (@(posedge clk) disable iff (!nrst)
        enable && s_q.active && tick && s_q.cnt == `UIRX_LAST_TICK
        && !pulse |=> s_q.out)
        else $error("ir cell did not end high");
endmodule : uirx_irdec

//--- rtl/uirx_params.svh
/*
 Register offsets, field positions, reset values and bit timing
 for the serial port with infrared receive decoder.
 Assumes an 8-bit register file addressed with 12-bit addresses.
*/
`ifndef UIRX_PARAMS_SVH
`define UIRX_PARAMS_SVH

// Register file offsets
`define UIRX_ADDR_DATA   12'hF40
`define UIRX_ADDR_STAT0  12'hF41
`define UIRX_ADDR_CTL0   12'hF42
`define UIRX_ADDR_CTL1   12'hF43
`define UIRX_ADDR_BRH    12'hF44
`define UIRX_ADDR_BRL    12'hF45

// Status 0 field positions
`define UIRX_S0_RXAV     7
`define UIRX_S0_PAR      6
`define UIRX_S0_OVR      5
`define UIRX_S0_FRM      4
`define UIRX_S0_BRK      3
`define UIRX_S0_THRE     2
`define UIRX_S0_TXIDLE   1
`define UIRX_S0_CTS      0

// Control 0 field positions and writable mask
`define UIRX_C0_TXEN     7
`define UIRX_C0_RXEN     6
`define UIRX_C0_GATE     5
`define UIRX_C0_PAREN    4
`define UIRX_C0_ODD      3
`define UIRX_C0_WMASK    8'hF8

// Control 1 field positions and writable mask
`define UIRX_C1_MP       7
`define UIRX_C1_TXNB     6
`define UIRX_C1_RXNB     5
`define UIRX_C1_BT       2
`define UIRX_C1_IR       1
`define UIRX_C1_WMASK    8'hC6

// Reset values
`define UIRX_CTL_RESET   8'h00
`define UIRX_BRG_RESET   16'hFFFF

// Bit timing in baud ticks; infrared idle limit in bit cells
`define UIRX_TICKS_PER_BIT 16
`define UIRX_MID_TICK    4'h7
`define UIRX_LAST_TICK   4'hF
`define UIRX_IR_IDLE_BITS 4'hA

`endif

//--- rtl/uirx_pkg.sv
/*
 Types shared by the serial port modules: frame phases and the
 packed state records of each module.
 Assumes uirx_params.svh for all numeric constants.
*/
package uirx_pkg;

    typedef enum logic [2:0] {
        PH_IDLE, PH_START, PH_DATA, PH_NINTH, PH_STOP
    } uirx_phase_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } uirx_baud_t;

    typedef struct packed {
        logic       prev;
        logic       active;
        logic [3:0] cnt;
        logic       seen;
        logic [3:0] idle_bits;
        logic       out;
    } uirx_irdec_t;

    typedef struct packed {
        logic [7:0]  rdata;
        logic        txd;
        logic        tx_irq;
        logic        rx_irq;
        logic        baud_irq;
        logic [7:0]  ctl0;
        logic [7:0]  ctl1;
        logic [15:0] brg;
        logic [7:0]  thr;
        logic        thr_empty;
        uirx_phase_t tx_ph;
        logic [3:0]  tx_cnt;
        logic [2:0]  tx_bit;
        logic [7:0]  tx_sh;
        logic        tx_nb;
        uirx_phase_t rx_ph;
        logic [3:0]  rx_cnt;
        logic [2:0]  rx_bit;
        logic [7:0]  rx_sh;
        logic        rx_nb;
        logic        rx_prev;
        logic [7:0]  rx_data;
        logic        rx_ninth;
        logic        rx_avail;
        logic        par_err;
        logic        ovr;
        logic        frm;
        logic        brk;
        logic        rxd_s1;
        logic        rxd_s2;
        logic        cts_s1;
        logic        cts_s2;
        logic [4:0]  chk_ticks;
    } uirx_state_t;

endpackage : uirx_pkg

//--- rtl/uirx_top.sv
/*
 Serial port with transmit holding register, receive status flags,
 flow gating, nine-bit mode, baud timer and infrared receive decoder.
 Assumes a CPU register strobe port on clk; serial pins are async.
*/
`timescale 1ns/1ps
`include "uirx_params.svh"

module uirx_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Register file port
    input  wire logic [11:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [7:0]       rdata,
    // Serial pins
    input  wire logic        rxd_pin,
    input  wire logic        cts_n_pin,
    output logic             txd,
    // Interrupt requests
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             baud_irq
);
    uirx_pkg::uirx_state_t s_q;
    uirx_pkg::uirx_state_t s_d;
    logic                  tick;
    logic                  ir_line;
    logic                  rx_line;
    logic                  rx_done;
    logic                  wr_data;
    logic                  rd_data;
    logic                  rd_stat;
    logic                  nb_en;
    logic                  gate_ok;

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    // Baud tick source shared by both directions and the decoder
    uirx_baud u_baud (
        .clk    (clk),
        .nrst   (nrst),
        .reload (s_q.brg),
        .tick   (tick)
    );

    // Optical input arrives on the receive pin in infrared mode
    uirx_irdec u_irdec (
        .clk           (clk),
        .nrst          (nrst),
        .enable        (s_q.ctl1[`UIRX_C1_IR]),
        .tick          (tick),
        .optical_rx_in (s_q.rxd_s2),
        .rx_line       (ir_line)
    );

    assign rx_line = s_q.ctl1[`UIRX_C1_IR] ? ir_line : s_q.rxd_s2;

    // Strobe decode
    assign wr_data = wr & hit(addr, `UIRX_ADDR_DATA);
    assign rd_data = rd & hit(addr, `UIRX_ADDR_DATA);
    assign rd_stat = rd & hit(addr, `UIRX_ADDR_STAT0);
    // Ninth bit in mode or parity
    assign nb_en = s_q.ctl1[`UIRX_C1_MP] | s_q.ctl0[`UIRX_C0_PAREN];
    assign gate_ok = ~(s_q.ctl0[`UIRX_C0_GATE] & s_q.cts_s2);

    // Next-state logic for registers, transmitter and receiver
    always_comb begin
        s_d = s_q;
        rx_done = 1'b0;
        s_d.rxd_s1 = rxd_pin;
        s_d.rxd_s2 = s_q.rxd_s1;
        s_d.cts_s1 = cts_n_pin;
        s_d.cts_s2 = s_q.cts_s1;
        s_d.rx_prev = rx_line;

        // Transmitter
        case (s_q.tx_ph)
            uirx_pkg::PH_IDLE: begin
                s_d.txd = 1'b1;
                if (!s_q.thr_empty && s_q.ctl0[`UIRX_C0_TXEN]
                    && gate_ok) begin
                    s_d.tx_sh = s_q.thr;
                    s_d.tx_nb = s_q.ctl1[`UIRX_C1_MP]
                        ? s_q.ctl1[`UIRX_C1_TXNB]
                        : (^s_q.thr) ^ s_q.ctl0[`UIRX_C0_ODD];
                    s_d.thr_empty = 1'b1;
                    s_d.tx_ph = uirx_pkg::PH_START;
                    s_d.tx_cnt = 4'h0;
                    s_d.txd = 1'b0;
                end
            end
            default: begin
                if (tick) begin
                    s_d.tx_cnt = s_q.tx_cnt + 4'h1;
                    if (s_q.tx_cnt == `UIRX_LAST_TICK) begin
                        case (s_q.tx_ph)
                            uirx_pkg::PH_START: begin
                                s_d.tx_ph = uirx_pkg::PH_DATA;
                                s_d.tx_bit = 3'h0;
                                s_d.txd = s_q.tx_sh[0];
                            end
                            uirx_pkg::PH_DATA: begin
                                s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
                                s_d.tx_bit = s_q.tx_bit + 3'h1;
                                s_d.txd = s_q.tx_sh[1];
                                if (s_q.tx_bit == 3'h7) begin
                                    s_d.tx_ph = nb_en
                                        ? uirx_pkg::PH_NINTH
                                        : uirx_pkg::PH_STOP;
                                    s_d.txd = nb_en ? s_q.tx_nb : 1'b1;
                                end
                            end
                            uirx_pkg::PH_NINTH: begin
                                s_d.tx_ph = uirx_pkg::PH_STOP;
                                s_d.txd = 1'b1;
                            end
                            default: begin
                                s_d.tx_ph = uirx_pkg::PH_IDLE;
                                s_d.txd = 1'b1;
                            end
                        endcase
                    end
                end
            end
        endcase

        // Helper count of ticks spent in the start bit
        if (s_q.tx_ph == uirx_pkg::PH_START) begin
            s_d.chk_ticks = s_q.chk_ticks + {4'h0, tick};
        end else begin
            s_d.chk_ticks = 5'h00;
        end

        // Receiver
        case (s_q.rx_ph)
            uirx_pkg::PH_IDLE: begin
                if (s_q.ctl0[`UIRX_C0_RXEN] && s_q.rx_prev
                    && !rx_line) begin
                    s_d.rx_ph = uirx_pkg::PH_START;
                    s_d.rx_cnt = 4'h0;
                end
            end
            uirx_pkg::PH_START: begin
                if (tick) begin
                    s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                    if (s_q.rx_cnt == `UIRX_MID_TICK) begin
                        s_d.rx_cnt = 4'h0;
                        s_d.rx_bit = 3'h0;
                        s_d.rx_ph = rx_line ? uirx_pkg::PH_IDLE
                                            : uirx_pkg::PH_DATA;
                    end
                end
            end
            default: begin
                if (tick) begin
                    s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                    if (s_q.rx_cnt == `UIRX_LAST_TICK) begin
                        case (s_q.rx_ph)
                            uirx_pkg::PH_DATA: begin
                                s_d.rx_sh = {rx_line, s_q.rx_sh[7:1]};
                                s_d.rx_bit = s_q.rx_bit + 3'h1;
                                s_d.rx_nb = 1'b0;
                                if (s_q.rx_bit == 3'h7) begin
                                    s_d.rx_ph = nb_en
                                        ? uirx_pkg::PH_NINTH
                                        : uirx_pkg::PH_STOP;
                                end
                            end
                            uirx_pkg::PH_NINTH: begin
                                s_d.rx_nb = rx_line;
                                s_d.rx_ph = uirx_pkg::PH_STOP;
                            end
                            default: begin
                                rx_done = 1'b1;
                                s_d.rx_ph = uirx_pkg::PH_IDLE;
                            end
                        endcase
                    end
                end
            end
        endcase

        // Read side effects; a character ending now overrides them
        if (rd_data) begin
            s_d.rx_avail = 1'b0;
            s_d.frm = 1'b0;
            s_d.brk = 1'b0;
            if (!s_q.rx_avail) begin
                s_d.ovr = 1'b0;
            end
        end

        if (rx_done) begin
            s_d.rx_data = s_q.rx_sh;
            s_d.rx_ninth = s_q.rx_nb;
            s_d.rx_avail = 1'b1;
            if (s_q.rx_avail) begin
                s_d.ovr = 1'b1;
            end
            if (!rx_line) begin
                s_d.frm = 1'b1;
            end
            if (s_q.rx_sh == 8'h00 && !s_q.rx_nb && !rx_line) begin
                s_d.brk = 1'b1;
            end
            s_d.par_err = s_q.ctl0[`UIRX_C0_PAREN]
                & ~s_q.ctl1[`UIRX_C1_MP]
                & (s_q.rx_nb ^ (^s_q.rx_sh) ^ s_q.ctl0[`UIRX_C0_ODD]);
        end

        if (wr) begin
            if (hit(addr, `UIRX_ADDR_DATA)) begin
                s_d.thr = wdata;
                s_d.thr_empty = 1'b0;
            end else if (hit(addr, `UIRX_ADDR_CTL0)) begin
                s_d.ctl0 = wdata & `UIRX_C0_WMASK;
            end else if (hit(addr, `UIRX_ADDR_CTL1)) begin
                s_d.ctl1 = wdata & `UIRX_C1_WMASK;
            end else if (hit(addr, `UIRX_ADDR_BRH)) begin
                s_d.brg[15:8] = wdata;
            end else if (hit(addr, `UIRX_ADDR_BRL)) begin
                s_d.brg[7:0] = wdata;
            end
        end

        // Register reads; unmapped addresses read zero
        if (rd) begin
            if (hit(addr, `UIRX_ADDR_DATA)) begin
                s_d.rdata = s_q.rx_data;
            end else if (hit(addr, `UIRX_ADDR_STAT0)) begin
                s_d.rdata = 8'h00;
                s_d.rdata[`UIRX_S0_RXAV] = s_q.rx_avail;
                s_d.rdata[`UIRX_S0_PAR] = s_q.par_err;
                s_d.rdata[`UIRX_S0_OVR] = s_q.ovr;
                s_d.rdata[`UIRX_S0_FRM] = s_q.frm;
                s_d.rdata[`UIRX_S0_BRK] = s_q.brk;
                s_d.rdata[`UIRX_S0_THRE] = s_q.thr_empty;
                s_d.rdata[`UIRX_S0_TXIDLE] =
                    (s_q.tx_ph == uirx_pkg::PH_IDLE);
                s_d.rdata[`UIRX_S0_CTS] = s_q.cts_s2;
            end else if (hit(addr, `UIRX_ADDR_CTL0)) begin
                s_d.rdata = s_q.ctl0;
            end else if (hit(addr, `UIRX_ADDR_CTL1)) begin
                s_d.rdata = s_q.ctl1;
                s_d.rdata[`UIRX_C1_RXNB] = s_q.rx_ninth;
            end else if (hit(addr, `UIRX_ADDR_BRH)) begin
                s_d.rdata = s_q.brg[15:8];
            end else if (hit(addr, `UIRX_ADDR_BRL)) begin
                s_d.rdata = s_q.brg[7:0];
            end else begin
                s_d.rdata = 8'h00;
            end
        end

        s_d.tx_irq = s_d.thr_empty & s_d.ctl0[`UIRX_C0_TXEN];
        s_d.rx_irq = s_d.rx_avail;
        s_d.baud_irq = tick & s_q.ctl1[`UIRX_C1_BT];
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.txd <= 1'b1;
            s_q.thr_empty <= 1'b1;
            s_q.ctl0 <= `UIRX_CTL_RESET;
            s_q.ctl1 <= `UIRX_CTL_RESET;
            s_q.brg <= `UIRX_BRG_RESET;
            s_q.rxd_s1 <= 1'b1;
            s_q.rxd_s2 <= 1'b1;
            s_q.cts_s1 <= 1'b1;
            s_q.cts_s2 <= 1'b1;
            s_q.rx_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign rdata = s_q.rdata;
    assign txd = s_q.txd;
    assign tx_irq = s_q.tx_irq;
    assign rx_irq = s_q.rx_irq;
    assign baud_irq = s_q.baud_irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_load;
        s_q.tx_ph == uirx_pkg::PH_IDLE && !s_q.thr_empty
        && s_q.ctl0[`UIRX_C0_TXEN] && gate_ok && !wr_data;
    endsequence

    sequence s_started;
        s_q.tx_ph == uirx_pkg::PH_START && s_q.thr_empty && !s_q.txd;
    endsequence

    chk_data_write: assert property (wr_data |=> !s_q.thr_empty)
        else $error("write did not clear holding empty");

    chk_auto_load: assert property (s_load |=> s_started)
        else $error("held byte not moved to shifter");

    chk_start_len: assert property (
        s_q.tx_ph == uirx_pkg::PH_START
        && s_d.tx_ph == uirx_pkg::PH_DATA |-> s_q.chk_ticks == 5'h0F)
        else $error("start bit not sixteen ticks");

    chk_flow_block: assert property (
        s_q.tx_ph == uirx_pkg::PH_IDLE && !gate_ok
        |=> s_q.tx_ph == uirx_pkg::PH_IDLE)
        else $error("transmit started while gated");

    chk_idle_read: assert property (
        rd_stat && s_q.tx_ph != uirx_pkg::PH_IDLE
        |=> !s_q.rdata[`UIRX_S0_TXIDLE])
        else $error("idle flag high while shifting");

    chk_rx_readback: assert property (
        rd_data |=> s_q.rdata == $past(s_q.rx_data))
        else $error("data read did not return receive data");

    chk_overrun_set: assert property (
        rx_done && s_q.rx_avail |=> s_q.ovr && s_q.rx_avail)
        else $error("overrun not flagged");

    chk_overrun_keep: assert property (
        rd_data && s_q.rx_avail && !rx_done |=> s_q.ovr == $past(s_q.ovr))
        else $error("overrun cleared while data available");

    chk_read_clear: assert property (
        rd_data && !rx_done |=> !s_q.frm && !s_q.brk && !s_q.rx_avail)
        else $error("data read did not clear flags");

    chk_timer_irq: assert property (
        tick && s_q.ctl1[`UIRX_C1_BT] |=> s_q.baud_irq)
        else $error("baud timer tick gave no interrupt");

    chk_timer_quiet: assert property (
        !(tick && s_q.ctl1[`UIRX_C1_BT]) |=> !s_q.baud_irq)
        else $error("baud interrupt without timer tick");
endmodule : uirx_top

//--- tb/tb_uirx_top.sv
/* Self-checking bench for the serial port register interface.
   Assumes baud reload 2, so one serial bit is 32 clocks. */
`timescale 1ns/1ps
module tb_uirx_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        cts_n_pin = 1'b1;
    logic [7:0]  rdata, got, n;
    logic        rxd_pin, txd, baud_irq, tx_irq, rx_irq;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    always #5 clk = ~clk;
    uirx_top dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rxd_pin(rxd_pin),
        .cts_n_pin(cts_n_pin), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq),
        .baud_irq(baud_irq));
    uirx_remote #(.BIT_CLKS(32)) rem_u (.clk(clk), .txd(txd),
        .rxd_pin(rxd_pin), .got(got));
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic cmp(input string s, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : cmp
    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk) #1;
        wr = 1'b0;
        // Let an edge pass before the next strobe
        @(posedge clk) #1;
    endtask : wreg
    // Read, then compare the masked bits
    task automatic rchk(input logic [11:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        @(posedge clk) #1;
        rd = 1'b0;
        cmp($sformatf("reg %h", a), e, rdata & m);
        @(posedge clk) #1;
    endtask : rchk
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        rchk(12'hF41, 8'hFF, 8'h07);
        rchk(12'hF42, 8'hFF, 8'h00);
        rchk(12'hF46, 8'hFF, 8'h00);
        wreg(12'hF44, 8'h00);
        wreg(12'hF45, 8'h02);
        // New reload applies only when the FFFF count loaded after reset runs out
        repeat (65536) @(posedge clk) #1;
        cts_n_pin = 1'b0;
        repeat (4) @(posedge clk) #1;
        rchk(12'hF41, 8'h01, 8'h00);
        wreg(12'hF42, 8'hE0);
        cmp("tx_irq", 8'h01, {7'h00, tx_irq});
        wreg(12'hF40, 8'hA5);
        repeat (10) @(posedge clk) #1;
        rchk(12'hF41, 8'h06, 8'h04);
        wreg(12'hF40, 8'h5A);
        rchk(12'hF41, 8'h04, 8'h00);
        repeat (290) @(posedge clk) #1;
        cmp("tx byte", 8'hA5, got);
        repeat (330) @(posedge clk) #1;
        cmp("tx byte", 8'h5A, got);
        repeat (60) @(posedge clk) #1;
        rchk(12'hF41, 8'h06, 8'h06);
        // Clear-to-send passes two sync stages before gating
        cts_n_pin = 1'b1;
        repeat (4) @(posedge clk) #1;
        wreg(12'hF40, 8'h11);
        repeat (100) @(posedge clk) #1;
        rchk(12'hF41, 8'h06, 8'h02);
        cmp("tx_irq", 8'h00, {7'h00, tx_irq});
        cts_n_pin = 1'b0;
        repeat (400) @(posedge clk) #1;
        cmp("tx byte", 8'h11, got);
        rem_u.send(8'h3C, 1'b1);
        rchk(12'hF41, 8'hB8, 8'h80);
        cmp("rx_irq", 8'h01, {7'h00, rx_irq});
        rchk(12'hF40, 8'hFF, 8'h3C);
        rchk(12'hF41, 8'h80, 8'h00);
        cmp("rx_irq", 8'h00, {7'h00, rx_irq});
        rem_u.send(8'h11, 1'b1);
        rem_u.send(8'h22, 1'b1);
        rchk(12'hF41, 8'h20, 8'h20);
        rchk(12'hF40, 8'hFF, 8'h22);
        rchk(12'hF41, 8'h20, 8'h20);
        rchk(12'hF40, 8'hFF, 8'h22);
        rchk(12'hF41, 8'h20, 8'h00);
        rem_u.send(8'h00, 1'b0);
        repeat (40) @(posedge clk) #1;
        rchk(12'hF41, 8'h18, 8'h18);
        rchk(12'hF40, 8'hFF, 8'h00);
        rchk(12'hF41, 8'h18, 8'h00);
        // Even parity: a ninth bit of 0 after data 01 is wrong
        wreg(12'hF42, 8'hF0);
        rem_u.send(8'h01, 1'b0);
        repeat (40) @(posedge clk) #1;
        rchk(12'hF41, 8'h78, 8'h40);
        rchk(12'hF40, 8'hFF, 8'h01);
        wreg(12'hF42, 8'hE0);
        // Infrared enabled before the optical line is driven
        wreg(12'hF43, 8'h02);
        rem_u.send_ir(8'hC5);
        rchk(12'hF41, 8'hF8, 8'h80);
        rchk(12'hF40, 8'hFF, 8'hC5);
        wreg(12'hF43, 8'h06);
        n = 8'h00;
        repeat (20) @(posedge clk) #1 n = n + {7'h00, baud_irq};
        cmp("baud pulses", 8'h0A, n);
        print_verdict();
    end
endmodule : tb_uirx_top

//--- tb/uirx_remote.sv
/* Remote serial port: sends 8-bit frames, plain or as optical pulses,
   on the receive pin and captures bytes from the transmit pin.
   Assumes one stop bit and a fixed bit time in clocks. */
`timescale 1ns/1ps
module uirx_remote #(
    parameter int BIT_CLKS = 32
) (
    // Clock
    input  wire logic  clk,
    // Serial lines
    input  wire logic  txd,
    output logic       rxd_pin,
    output logic [7:0] got
);
    initial begin
        rxd_pin = 1'b1;
        got = 8'h00;
    end
    // Send start, LSB first data, then given stop level
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk) #1;
            rxd_pin = f[i];
            repeat (BIT_CLKS - 1) @(posedge clk);
        end
        @(posedge clk) #1;
        rxd_pin = 1'b1;
    endtask : send
    // Optical frame: idle low, a short high pulse opens each zero cell
    task automatic send_ir(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        @(posedge clk) #1;
        rxd_pin = 1'b0;
        repeat (8) @(posedge clk) #1;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk) #1;
            rxd_pin = ~f[i];
            repeat (3) @(posedge clk) #1;
            rxd_pin = 1'b0;
            repeat (BIT_CLKS - 4) @(posedge clk) #1;
        end
    endtask : send_ir
    // sample each data bit at mid cell
    always begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            got[i] = txd;
        end
        repeat (BIT_CLKS) @(posedge clk);
    end
endmodule : uirx_remote
